// [rtl/vcd_clock_ctrl.v]
// Calibration sequencer, frequency monitors, source select and three channel dividers.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "vcd_defines.vh"
// Register map, by word index; the byte address on the bus is four times the index.
// Only bits 7:0 of each word carry state; the upper read bits are always zero.
//   pll_cal_control  calibration control: bit 0 start, bits 2:1 calibration divisor 1, 2, 4, 8.
//   ref_monitor_threshold_select  monitor thresholds: bit 0 extended for reference 1, bit 1 for reference 2.
//   pll_readback_status  status, read only: bit 6 calibration done, bits 3:1 low flags.
//   distribution_source_select  distribution source, bits 1:0; code 11 is refused and the field is kept.
//   register_update_trigger  update trigger: writing bit 0 high gives a one-cycle update pulse.
//   0x300  VCO divider field, 0 to 4 for ratios 2 to 6; larger codes are refused.
//   0x310  plus twice the channel: low count in bits 7:4, high count in bits 3:0.
//   0x311  plus twice the channel: bypass, correction off, start high, phase delay.
//
// Bus timing: the slave never stretches a transfer, so hreadyout stays high and the
// response is always OKAY. Read data is registered in the address phase so that it
// stands for the whole data phase; write data is taken at the end of the data phase.
//
// Calibration timing: the update pulse follows the write by one cycle and the sync
// rises one cycle later. Phase-detector edges reach the sequencer three bus cycles
// after the pin, through the synchroniser and the edge detector. The sequencer does
// not look at updates while it runs; software must wait for done before rearming.
//
// Limitations: every clock input is sampled by the bus clock, so each must toggle
// well below half the bus rate or edges will be lost. This trades exact analog
// timing for a single clock domain and a design that is simple to check.
// The duty-cycle correction drives the output high in the next-to-last low input cycle and low again in the last.
//
// Monitors: each counts rising edges over a fixed window of bus cycles. At the end
// of a window the count is compared with the threshold and the flag is refreshed,
// so a flag may lag a change of input frequency by up to two windows.
//
// Channel dividers: while the sync is high the outputs rest at their start level
// and the phase delay is reloaded, so all three restart together when it falls.
//
module vcd_clock_ctrl (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire pfd_tick_in,
  input wire ref1_tick_in,
  input wire ref2_tick_in,
  input wire vco_tick_in,
  input wire clk_tick_in,
  input wire ext_feedback_in,
  output reg [2:0] ch_out,
  output reg sync_active,
  output reg dist_tick
);
  // Pin inputs cross into the bus clock domain through two flip-flops.
  reg [5:0] sync1_q;
  reg [5:0] sync2_q;
  reg [4:0] edge_q;
  wire pfd_rise = sync2_q[0] & ~edge_q[0];
  wire ref1_rise = sync2_q[1] & ~edge_q[1];
  wire ref2_rise = sync2_q[2] & ~edge_q[2];
  wire vco_rise = sync2_q[3] & ~edge_q[3];
  wire clk_rise = sync2_q[4] & ~edge_q[4];
  wire ext_fb = sync2_q[5];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      edge_q <= 5'h00;
    end else begin
      sync1_q <= {ext_feedback_in, clk_tick_in, vco_tick_in, ref2_tick_in, ref1_tick_in,
                  pfd_tick_in};
      sync2_q <= sync1_q;
      edge_q <= sync2_q[4:0];
    end
  end

  // Register file.
  reg [7:0] cal_ctrl_q;
  reg [7:0] mon_thr_q;
  reg [1:0] src_sel_q;
  reg [2:0] vdiv_q;
  reg [7:0] ch_mn_q [0:2];
  reg [7:0] ch_ctl_q [0:2];
  reg update_q;
  reg armed_q;
  reg cal_done_q;
  reg [2:0] mon_low_q;

  // AHB-Lite address phase capture; every transfer completes with zero wait states.
  reg wr_pend_q;
  reg [11:0] wr_addr_q;
  wire addr_ok = hsel & htrans[1] & hready;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      if (addr_ok)
        wr_addr_q <= haddr[13:2];
    end
  end

  // Register index is the printed offset; byte address is four times it.
  function [7:0] read_reg;
    input [11:0] idx;
    begin
      case (idx)
        `VCD_OFF_CAL_CTRL: read_reg = cal_ctrl_q;
        `VCD_OFF_MON_THR: read_reg = mon_thr_q;
        `VCD_OFF_STATUS: read_reg = {1'b0, cal_done_q, 2'b00, mon_low_q, 1'b0};
        `VCD_OFF_SRC_SEL: read_reg = {6'h00, src_sel_q};
        `VCD_OFF_UPDATE: read_reg = 8'h00;
        `VCD_OFF_VCO_DIV: read_reg = {5'h00, vdiv_q};
        `VCD_OFF_CH_BASE: read_reg = ch_mn_q[0];
        `VCD_OFF_CH_BASE + 12'h001: read_reg = ch_ctl_q[0];
        `VCD_OFF_CH_BASE + 12'h002: read_reg = ch_mn_q[1];
        `VCD_OFF_CH_BASE + 12'h003: read_reg = ch_ctl_q[1];
        `VCD_OFF_CH_BASE + 12'h004: read_reg = ch_mn_q[2];
        `VCD_OFF_CH_BASE + 12'h005: read_reg = ch_ctl_q[2];
        default: read_reg = 8'h00;
      endcase
    end
  endfunction

  // Read data is registered in the address phase so it stands in the data phase.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (addr_ok & ~hwrite)
      hrdata <= {24'h000000, read_reg(haddr[13:2])};
  end

  // Register writes in the data phase; the update trigger is a self-clearing pulse.
  integer i;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_ctrl_q <= `VCD_CTRL_RESET;
      mon_thr_q <= 8'h00;
      src_sel_q <= `VCD_SRC_RESET;
      vdiv_q <= `VCD_VDIV_RESET;
      update_q <= 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
        ch_mn_q[i] <= 8'h00;
        ch_ctl_q[i] <= 8'h00;
      end
    end else begin
      update_q <= 1'b0;
      if (wr_pend_q) begin
        case (wr_addr_q)
          `VCD_OFF_CAL_CTRL: cal_ctrl_q <= hwdata[7:0];
          `VCD_OFF_MON_THR: mon_thr_q <= hwdata[7:0];
          `VCD_OFF_SRC_SEL: begin
            // Code 11 is not allowed, so such a write is dropped.
            if (hwdata[1:0] != 2'b11)
              src_sel_q <= hwdata[1:0];
          end
          `VCD_OFF_UPDATE: update_q <= hwdata[0];
          `VCD_OFF_VCO_DIV: begin
            // Only ratios 2..6 exist; fields 0..4 encode them.
            if (hwdata[2:0] <= 3'd4)
              vdiv_q <= hwdata[2:0];
          end
          `VCD_OFF_CH_BASE: ch_mn_q[0] <= hwdata[7:0];
          `VCD_OFF_CH_BASE + 12'h001: ch_ctl_q[0] <= hwdata[7:0];
          `VCD_OFF_CH_BASE + 12'h002: ch_mn_q[1] <= hwdata[7:0];
          `VCD_OFF_CH_BASE + 12'h003: ch_ctl_q[1] <= hwdata[7:0];
          `VCD_OFF_CH_BASE + 12'h004: ch_mn_q[2] <= hwdata[7:0];
          `VCD_OFF_CH_BASE + 12'h005: ch_ctl_q[2] <= hwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // Calibration sequencer. The start bit is sampled only at an update, so a divider
  // change alone can never start a run; a new run needs the bit seen low then high.
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;
  reg [1:0] state_q;
  reg [12:0] cal_cnt_q;
  reg [2:0] caldiv_q;
  wire start_bit = cal_ctrl_q[`VCD_CAL_START_BIT];
  wire [2:0] cal_div_top = (3'd1 << cal_ctrl_q[2:1]) - 3'd1;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      armed_q <= 1'b1;
      cal_done_q <= 1'b0;
      cal_cnt_q <= 13'd0;
      caldiv_q <= 3'd0;
      sync_active <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (update_q & ~start_bit)
            armed_q <= 1'b1;
          if (update_q & start_bit & armed_q) begin
            state_q <= ST_RUN;
            armed_q <= 1'b0;
            cal_done_q <= 1'b0;
            sync_active <= 1'b1;
            cal_cnt_q <= 13'd0;
            caldiv_q <= 3'd0;
          end
        end
        ST_RUN: begin
          // Progress only on phase-detector ticks, so no reference means no progress.
          if (pfd_rise) begin
            if (caldiv_q == cal_div_top) begin
              caldiv_q <= 3'd0;
              if (cal_cnt_q == `VCD_CAL_CYCLES - 13'd1) begin
                state_q <= ST_IDLE;
                cal_done_q <= 1'b1;
                sync_active <= 1'b0;
              end else begin
                cal_cnt_q <= cal_cnt_q + 13'd1;
              end
            end else begin
              caldiv_q <= caldiv_q + 3'd1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Frequency monitors: count monitored edges in a fixed window of bus cycles and
  // flag too few. Threshold bits 0 and 1 pick extended for reference 1 and 2.
  reg [15:0] win_q;
  reg [15:0] mon_cnt_q [0:2];
  wire [2:0] mon_rise = {ext_fb ? clk_rise : vco_rise, ref2_rise, ref1_rise};
  function [15:0] mon_thr;
    input ext;
    begin
      mon_thr = ext ? `VCD_MON_EXTENDED : `VCD_MON_NORMAL;
    end
  endfunction
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_q <= 16'h0000;
      mon_low_q <= 3'b000;
      for (i = 0; i < 3; i = i + 1)
        mon_cnt_q[i] <= 16'h0000;
    end else begin
      // Restart the window at its end so each verdict covers exactly one window.
      if (win_q == `VCD_MON_WINDOW - 16'h0001)
        win_q <= 16'h0000;
      else
        win_q <= win_q + 16'h0001;
      for (i = 0; i < 3; i = i + 1) begin
        if (win_q == `VCD_MON_WINDOW - 16'h0001) begin
          mon_cnt_q[i] <= 16'h0000;
          if (i == 2)
            mon_low_q[i] <= mon_cnt_q[i] < `VCD_MON_NORMAL;
          else
            mon_low_q[i] <= mon_cnt_q[i] < mon_thr(mon_thr_q[i]);
        end else if (mon_rise[i] & (mon_cnt_q[i] != 16'hffff)) begin
          mon_cnt_q[i] <= mon_cnt_q[i] + 16'h0001;
        end
      end
    end
  end

  // Distribution source and VCO divider produce the channel divider input tick.
  reg [2:0] vdiv_cnt_q;
  wire src_rise = src_sel_q[1] ? vco_rise : clk_rise;
  wire use_vdiv = (src_sel_q != `VCD_SRC_CLK_DIRECT);
  reg src_tick;
  always @* begin
    src_tick = 1'b0;
    if (src_rise)
      src_tick = ~use_vdiv | (vdiv_cnt_q == vdiv_q + 3'd1);
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vdiv_cnt_q <= 3'd0;
      dist_tick <= 1'b0;
    end else begin
      dist_tick <= src_tick;
      if (src_rise)
        vdiv_cnt_q <= src_tick ? 3'd0 : vdiv_cnt_q + 3'd1;
    end
  end

  // Channel dividers. Control: bit7 bypass, bit6 dcc off, bit5 start high,
  // bits4:0 phase delay. Sync holds them at the start level and reloads the delay.
  // The fifty percent odd case toggles half a cycle early on the falling input edge,
  // which in this sampled model becomes a one-cycle high pulse in the next-to-last low input cycle.
  reg [4:0] ch_cnt_q [0:2];
  reg [4:0] ch_dly_q [0:2];
  reg [2:0] ch_hi_q;
  reg [2:0] ch_half_q;
  reg [2:0] ch_byp_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ch_out <= 3'b000;
      ch_hi_q <= 3'b000;
      ch_half_q <= 3'b000;
      ch_byp_q <= 3'b000;
      for (i = 0; i < 3; i = i + 1) begin
        ch_cnt_q[i] <= 5'd0;
        ch_dly_q[i] <= 5'd0;
      end
    end else begin
      for (i = 0; i < 3; i = i + 1) begin
        if (sync_active) begin
          ch_hi_q[i] <= ch_ctl_q[i][5];
          ch_dly_q[i] <= ch_ctl_q[i][4:0];
          ch_cnt_q[i] <= 5'd0;
          ch_half_q[i] <= 1'b0;
          ch_byp_q[i] <= 1'b0;
        end else if (ch_ctl_q[i][7]) begin
          if (dist_tick)
            ch_byp_q[i] <= ~ch_byp_q[i];
        end else if (dist_tick) begin
          if (ch_dly_q[i] != 5'd0) begin
            ch_dly_q[i] <= ch_dly_q[i] - 5'd1;
          end else if (ch_hi_q[i] ?
                       (ch_cnt_q[i] == {1'b0, ch_mn_q[i][3:0]}) :
                       (ch_cnt_q[i] == {1'b0, ch_mn_q[i][7:4]})) begin
            ch_hi_q[i] <= ~ch_hi_q[i];
            ch_cnt_q[i] <= 5'd0;
            // DCC flag: toggles at every phase change for any M and N; no output logic reads it.
            ch_half_q[i] <= ~ch_half_q[i];
          end else begin
            ch_cnt_q[i] <= ch_cnt_q[i] + 5'd1;
          end
        end
        // The start level is driven directly so outputs stop within one cycle of sync.
        if (sync_active)
          ch_out[i] <= ch_ctl_q[i][5];
        else if (ch_ctl_q[i][7])
          ch_out[i] <= ch_byp_q[i];
        else if (~ch_ctl_q[i][6] & (ch_mn_q[i][7:4] == ch_mn_q[i][3:0] + 4'd1) &
                 ~ch_hi_q[i] & (ch_cnt_q[i] == {1'b0, ch_mn_q[i][3:0]}) &
                 (ch_dly_q[i] == 5'd0) & ~sync_active)
          ch_out[i] <= 1'b1;
        else
          ch_out[i] <= ch_hi_q[i];
      end
    end
  end
endmodule // vcd_clock_ctrl
`default_nettype wire

// [rtl/vcd_defines.vh]
// Register offsets, field positions, reset values and timing counts of the clock controller.
`ifndef VCD_DEFINES_VH
`define VCD_DEFINES_VH
`define VCD_OFF_CAL_CTRL 12'h018
`define VCD_OFF_MON_THR 12'h01a
`define VCD_OFF_STATUS 12'h01f
`define VCD_OFF_SRC_SEL 12'h1e1
`define VCD_OFF_UPDATE 12'h232
`define VCD_OFF_VCO_DIV 12'h300
`define VCD_OFF_CH_BASE 12'h310
`define VCD_CAL_START_BIT 0
`define VCD_CAL_DONE_BIT 6
`define VCD_CAL_CYCLES 13'd4400
`define VCD_CTRL_RESET 8'h00
`define VCD_SRC_RESET 2'b10
`define VCD_VDIV_RESET 3'd0
`define VCD_MON_NORMAL 16'h0100
`define VCD_MON_EXTENDED 16'h0010
`define VCD_MON_WINDOW 16'h1000
`define VCD_SRC_CLK_VDIV 2'b00
`define VCD_SRC_CLK_DIRECT 2'b01
`define VCD_SRC_VCO_VDIV 2'b10
`endif

// [tb/test_vcd_clock_ctrl.sv]
// Bench for the clock controller: registers, calibration, monitors and a channel divider.
`timescale 1ns/100ps
`default_nettype none
`include "vcd_defines.vh"
module test_vcd_clock_ctrl;
  localparam logic [31:0] A_CTRL = {18'h0, `VCD_OFF_CAL_CTRL, 2'b00};
  localparam logic [31:0] A_THR = {18'h0, `VCD_OFF_MON_THR, 2'b00};
  localparam logic [31:0] A_STAT = {18'h0, `VCD_OFF_STATUS, 2'b00};
  localparam logic [31:0] A_SRC = {18'h0, `VCD_OFF_SRC_SEL, 2'b00};
  localparam logic [31:0] A_UPD = {18'h0, `VCD_OFF_UPDATE, 2'b00};
  localparam logic [31:0] A_CH = {18'h0, `VCD_OFF_CH_BASE, 2'b00};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic pfd_en = 1'b1, ext_fb = 1'b0, pfd = 1'b0, ref1 = 1'b0, ref2 = 1'b0, vco = 1'b0;
  logic clk_t = 1'b0;
  logic [6:0] tc = 7'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, sync_active, dist_tick;
  wire [2:0] ch_out;
  int err_count = 0;
  int n_compared = 0;
  vcd_clock_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pfd_tick_in(pfd),
    .ref1_tick_in(ref1), .ref2_tick_in(ref2), .vco_tick_in(vco), .clk_tick_in(clk_t),
    .ext_feedback_in(ext_fb), .ch_out(ch_out), .sync_active(sync_active),
    .dist_tick(dist_tick));
  // Bus clock, 50 ns period.
  always #25 hclk = ~hclk;
  // Test clocks: ref2 and clk are slow enough to trip the normal threshold, ref1 and vco not.
  always @(posedge hclk) begin
    tc <= tc + 7'h1;
    pfd <= pfd_en ? tc[1] : pfd;
    ref1 <= tc[1];
    ref2 <= tc[6];
    vco <= tc[1];
    clk_t <= tc[4];
  end
  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cmpr(input string nm, input int lo, input int hi, input int s);
    n_compared++;
    if (s < lo || s > hi) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, s);
    end
  endtask
  task automatic wait_rdy(inout int n);
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
  endtask
  // One single AHB transfer; read data is taken at the edge that ends the data phase.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    wait_rdy(n);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy(n);
    q = hrdata;
    if (n >= 50) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic wsync(input logic lv, input int lim, output int c);
    c = 0;
    while (sync_active !== lv && c < lim) begin
      @(posedge hclk);
      c++;
    end
    if (c >= lim) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic t_reset();
    logic [31:0] q;
    rd(A_CTRL, q);
    cmp("ctrl_rst", {24'h0, `VCD_CTRL_RESET}, q);
    rd(A_SRC, q);
    cmp("src_rst", {30'h0, `VCD_SRC_RESET}, q);
    rd(32'h4, q);
    cmp("unmapped", 32'h0, q);
    rd(A_STAT, q);
    cmp("done_rst", 32'h0, q & 32'h40);
  endtask
  // Codes 3, 0, 1, 2 in turn; the forbidden code must leave the field alone.
  task automatic t_src();
    logic [31:0] q;
    logic [1:0] c, e;
    e = `VCD_SRC_RESET;
    for (int i = 3; i < 7; i++) begin
      c = i[1:0];
      wr(A_SRC, {30'h0, c});
      if (c != 2'b11) e = c;
      rd(A_SRC, q);
      cmp("src_sel", {30'h0, e}, q);
    end
  endtask
  // The pfd clock is stopped for 200 cycles mid-run; the wait must stretch by that much.
  task automatic t_cal(input logic [1:0] dv, input logic later);
    int c, s, e;
    logic [31:0] q;
    if (later) begin
      wr(A_CTRL, 32'h0);
      wr(A_UPD, 32'h1);
    end
    pfd_en <= 1'b1;
    wr(A_CTRL, {29'h0, dv, 1'b1});
    wr(A_UPD, 32'h1);
    wsync(1'b1, 10, c);
    rd(A_STAT, q);
    cmp("done_busy", 32'h0, q & 32'h40);
    pfd_en <= 1'b0;
    repeat (200) @(posedge hclk);
    pfd_en <= 1'b1;
    wsync(1'b0, 40000, s);
    e = (4400 << dv) * 4 + 200;
    cmpr("cal_cycles", e - 6, e + 8, s + 202);
    rd(A_STAT, q);
    cmp("done_set", 32'h40, q & 32'h40);
  endtask
  task automatic t_refuse();
    wr(A_UPD, 32'h1);
    wr({18'h0, `VCD_OFF_VCO_DIV, 2'b00}, 32'h3);
    repeat (6) @(posedge hclk);
    cmp("sync_idle", 32'h0, {31'h0, sync_active});
  endtask
  task automatic t_mon();
    logic [31:0] q;
    rd(A_STAT, q);
    cmp("mon_norm", 32'h4, q & 32'he);
    wr(A_THR, 32'h2);
    ext_fb <= 1'b1;
    repeat (8300) @(posedge hclk);
    rd(A_STAT, q);
    cmp("mon_ext", 32'h8, q & 32'he);
  endtask
  task automatic wch(input logic v, inout int n, output int t);
    t = 0;
    while (ch_out[0] === v && n < 3000) begin
      t += (dist_tick === 1'b1);
      @(posedge hclk);
      n++;
    end
  endtask
  // Channel 0 with M=2, N=1, correction off, fed by the external clock direct.
  task automatic t_div();
    int n, h, l;
    n = 0;
    wr(A_SRC, 32'h1);
    wr(A_CH, 32'h21);
    wr(A_CH + 32'h4, 32'h40);
    wch(1'b1, n, h);
    wch(1'b0, n, l);
    wch(1'b1, n, h);
    wch(1'b0, n, l);
    if (n >= 3000) begin
      err_count++;
      end_of_test();
    end
    cmp("ch_high", 32'd2, h);
    cmp("ch_low", 32'd3, l);
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_src();
    t_cal(2'b00, 1'b0);
    t_refuse();
    t_cal(2'b01, 1'b1);
    t_mon();
    t_div();
    end_of_test();
  end
endmodule // test_vcd_clock_ctrl
`default_nettype wire

// [tb/vcd_clock_ctrl_chk.sv]
// Concurrent checks on the clock controller's bus answer and calibration sequencing.
`timescale 1ns/100ps
`default_nettype none
`include "vcd_defines.vh"
module vcd_clock_ctrl_chk (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire pfd_tick_in,
  input wire [2:0] ch_out,
  input wire sync_active
);
  localparam int CAL_N = 4400;
  logic wr_q, ctl_q, arm_q;
  logic [11:0] ix_q;
  logic [1:0] dv_q;
  int pe_q;
  wire upd = wr_q && ix_q == `VCD_OFF_UPDATE && hwdata[0];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Shadow of start bit, divisor and arming; pfd pin edges counted from the rise of sync.
  // The raw pin is counted, so the design's synchroniser delay costs at most one edge.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      ix_q <= 12'h0;
      ctl_q <= 1'b0;
      dv_q <= 2'b00;
      arm_q <= 1'b1;
      pe_q <= 0;
    end else begin
      wr_q <= hsel & htrans[1] & hready & hwrite;
      ix_q <= haddr[13:2];
      if (wr_q && ix_q == `VCD_OFF_CAL_CTRL) begin
        ctl_q <= hwdata[0];
        dv_q <= hwdata[2:1];
      end
      if (upd) begin
        arm_q <= ~ctl_q;
      end
      if ($rose(sync_active)) begin
        pe_q <= 0;
      end else if ($rose(pfd_tick_in)) begin
        pe_q <= pe_q + 1;
      end
    end
  end
  chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
  chk_cal_start: assert property (upd && ctl_q && arm_q && !sync_active |-> ##[1:3] sync_active)
    else $error("calibration did not start");
  chk_repeat_refused: assert property (upd && !arm_q && !sync_active |-> ##1 (!sync_active) [*3])
    else $error("unarmed update started calibration");
  chk_no_auto_start: assert property ($rose(sync_active) |-> $past(upd) || $past(upd, 2) || $past(upd, 3))
    else $error("calibration started without update");
  chk_sync_static: assert property (sync_active && $past(sync_active) && $past(sync_active, 2) |-> $stable(ch_out))
    else $error("outputs moved during calibration");
  chk_sync_hold: assert property ($rose(sync_active) |-> sync_active [*8])
    else $error("sync dropped early");
  chk_cal_length: assert property ($fell(sync_active) |->
    pe_q >= (CAL_N << dv_q) - 1 && pe_q <= (CAL_N << dv_q) + 1) else $error("calibration length");
  cov_cal_start: cover property (upd && ctl_q && arm_q);
  cov_cal_end: cover property ($fell(sync_active));
  cov_refused: cover property (upd && ctl_q && !arm_q);
endmodule // vcd_clock_ctrl_chk
bind vcd_clock_ctrl vcd_clock_ctrl_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .pfd_tick_in(pfd_tick_in), .ch_out(ch_out),
  .sync_active(sync_active));
`default_nettype wire
